/* File: rtl/sacp_device.sv */
`timescale 1ns/1ps
// Functional notes
// R01 - select fall: hold, sample, start, drive
// R02 - conversion needs sixteen serial clock cycles
// R03 - fourteenth falling edge returns sampler tracking
// R04 - sixteenth falling edge releases data line
// R05 - early select rise aborts, releases line
// R06 - first zero shown at select fall
// R07 - each fall shifts next bit out
// R08 - rising-edge master reads first zero early
// R09 - four zeros then result, MSB first
// R10 - self-timed mode after power-up
// R11 - self-timed conversion ends within window
// R12 - clock edge in window forces clocked
// R13 - forced switch abandons self-timed conversion
// R14 - edgeless select pulse returns self-timed
// R15 - edges during select keep clocked mode
// R16 - power-down only from clocked mode
// R17 - rise after 4th, before 11th: sleep
// R18 - power-down drives analog power control
// R19 - wake needs select low past 11th
// R20 - early rise during wake: sleep again
// R21 - slow clock: one dummy cycle wakes
// R22 - after wake time, shortened dummy allowed
// R23 - master waits quiet interval after dummy
// R24 - falling-edge counter cleared at select fall
module sacp_device #(
    parameter int CONV_CYCLES = sacp_pkg::CONV_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // serial link
    sacp_if.device link,
    // analog front end, digital view
    input wire logic [sacp_pkg::RESULT_BITS-1:0] i_analog_input,
    output logic o_hold,
    output logic o_analog_pd,
    // status
    output logic o_clocked_mode,
    output logic o_busy,
    output logic o_result_ready
);
    localparam int TW = $clog2(CONV_CYCLES + 1);
    localparam int WB = sacp_pkg::WORD_BITS;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic cs_lvl;
    logic cs_rise;
    logic cs_fall;
    logic sc_lvl;
    logic sc_rise;
    logic sc_fall;

    sacp_edge_sync #(.RST_VAL(1'b1)) u_cs_sync (.i_clk(i_clk), .i_rst(i_rst),
        .i_pin(link.chip_select_n), .o_level(cs_lvl), .o_rise(cs_rise), .o_fall(cs_fall));

    sacp_edge_sync #(.RST_VAL(1'b0)) u_sc_sync (.i_clk(i_clk), .i_rst(i_rst),
        .i_pin(link.sclk), .o_level(sc_lvl), .o_rise(sc_rise), .o_fall(sc_fall));

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sacp_pkg::sacp_mode_t mode_r;
    logic frame_r;
    logic edge_seen_r;
    logic pd_r;
    logic hold_r;
    logic busy_r;
    logic armed_r;
    logic oe_r;
    logic apd_r;
    logic [4:0] cnt_r;
    logic [TW-1:0] timer_r;
    logic [sacp_pkg::RESULT_BITS-1:0] sample_r;
    logic [WB-1:0] shift_r;

    // ------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------
    wire clocked = (mode_r == sacp_pkg::SACP_CLOCKED);
    wire cs_low = ~cs_lvl;
    wire sc_edge = sc_rise | sc_fall;
    wire c_start = clocked & cs_fall;
    wire c_end = clocked & frame_r & cs_rise;
    wire c_fall = clocked & frame_r & cs_low & sc_fall;
    wire s_start = ~clocked & cs_fall;
    // R12 edge in window
    wire glitch = ~clocked & busy_r & cs_low & sc_edge;
    wire s_done = busy_r & ~glitch & (timer_r == TW'(1));
    // self-timed read opens on the first rising clock after the result lands
    wire r_open = ~clocked & armed_r & ~oe_r & sc_rise & (cnt_r == 5'h00);
    wire r_fall = ~clocked & oe_r & sc_fall;
    wire shift_fall = c_fall | r_fall;
    wire cnt_full = (cnt_r >= sacp_pkg::LAST_EDGE);
    wire last_fall = shift_fall & (cnt_r == sacp_pkg::LAST_EDGE - 5'h01);
    wire track_fall = c_fall & (cnt_r == sacp_pkg::TRACK_EDGE - 5'h01);
    // R17 sleep window
    wire pd_enter = c_end & ~pd_r & (cnt_r >= sacp_pkg::PD_FIRST)
        & (cnt_r < sacp_pkg::PD_LIMIT);
    // R19 wake past 11th
    wire wake_ok = c_end & pd_r & (cnt_r >= sacp_pkg::PD_LIMIT);
    // R14 edgeless pulse
    wire to_self = c_end & ~edge_seen_r & ~pd_r;

    // ------------------------------------------------------------
    // operating mode
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        // R10 self-timed default
        if (i_rst) begin
            mode_r <= sacp_pkg::SACP_SELF;
        end else if (glitch) begin
            mode_r <= sacp_pkg::SACP_CLOCKED;
        end else if (to_self) begin
            mode_r <= sacp_pkg::SACP_SELF;
        end
    end

    // ------------------------------------------------------------
    // clocked frame tracking
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            frame_r <= 1'b0;
        end else if (c_start | glitch) begin
            frame_r <= 1'b1;
        end else if (cs_rise) begin
            frame_r <= 1'b0;
        end
    end
    // R15 edges keep mode
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            edge_seen_r <= 1'b0;
        end else if (c_start) begin
            edge_seen_r <= 1'b0;
        end else if (glitch | (frame_r & cs_low & sc_edge)) begin
            edge_seen_r <= 1'b1;
        end
    end
    // R24 edge counter
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= 5'h00;
        end else if (c_start | s_start | glitch) begin
            cnt_r <= 5'h00;
        end else if (shift_fall & ~cnt_full) begin
            cnt_r <= cnt_r + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // power-down
    // ------------------------------------------------------------
    // R16 clocked only
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pd_r <= 1'b0;
        end else if (pd_enter) begin
            pd_r <= 1'b1;
        end else if (wake_ok) begin
            pd_r <= 1'b0;
        end
    end
    // R18 analog power control
    // powering up begins at select fall, so the control drops during a frame
    // R20 early rise resleeps
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            apd_r <= 1'b0;
        end else begin
            apd_r <= pd_r & ~(frame_r & cs_low);
        end
    end

    // ------------------------------------------------------------
    // track and hold
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hold_r <= 1'b0;
        end else if (c_start | s_start) begin
            // R01 hold at start
            hold_r <= 1'b1;
        end else if (track_fall | s_done | glitch | c_end) begin
            // R03 back to track
            hold_r <= 1'b0;
        end
    end
    // sampled value is data, not control: no reset needed
    always_ff @(posedge i_clk) begin
        if (c_start | s_start) begin
            sample_r <= i_analog_input;
        end
    end

    // ------------------------------------------------------------
    // self-timed conversion
    // ------------------------------------------------------------
    // R11 window timer
    // R13 abandon on switch
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            busy_r <= 1'b0;
            timer_r <= '0;
        end else if (s_start) begin
            busy_r <= 1'b1;
            timer_r <= TW'(CONV_CYCLES);
        end else if (glitch | s_done) begin
            busy_r <= 1'b0;
            timer_r <= '0;
        end else if (busy_r) begin
            timer_r <= timer_r - TW'(1);
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            armed_r <= 1'b0;
        end else if (s_done) begin
            armed_r <= 1'b1;
        end else if (clocked | s_start | (last_fall & ~clocked)) begin
            armed_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // output shifter
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            shift_r <= '0;
        end else if (c_start) begin
            // R09 zeros then MSB
            // R06 first zero now
            shift_r <= {{sacp_pkg::LEAD_ZEROS{1'b0}}, i_analog_input};
        end else if (s_done) begin
            shift_r <= {{sacp_pkg::LEAD_ZEROS{1'b0}}, sample_r};
        end else if (shift_fall & ~cnt_full) begin
            // R07 shift per fall
            shift_r <= {shift_r[WB-2:0], 1'b0};
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            oe_r <= 1'b0;
        end else if (c_start) begin
            // R01 drive line
            oe_r <= 1'b1;
        end else if ((c_end & ~cnt_full) | last_fall | glitch | s_start) begin
            // R05 abort release
            // R04 release at 16th
            // R02 sixteen cycles
            oe_r <= 1'b0;
        end else if (r_open) begin
            oe_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // undriven line reads as the opposite bit, so a sample taken too early shows up
    assign link.serial_out = oe_r ? shift_r[WB-1] : ~shift_r[WB-1];
    assign link.serial_out_oe = oe_r;
    assign o_hold = hold_r;
    assign o_analog_pd = apd_r;
    assign o_clocked_mode = mode_r;
    assign o_busy = busy_r;
    assign o_result_ready = armed_r;
endmodule

/* File: rtl/sacp_pkg.sv */
package sacp_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int CONV_WINDOW_NS = 3300;
    // longest time: round down
    localparam int CONV_CYCLES = (CONV_WINDOW_NS * CLK_MHZ) / 1000;
    localparam int WAKE_NS = 4330;
    // least time: round up
    localparam int WAKE_CYCLES = (WAKE_NS * CLK_MHZ + 999) / 1000;
    // data comes back to the master 7 cycles after a link clock edge
    localparam int SCLK_HALF = 8;
    localparam int QUIET_CYCLES = 16;

    // ------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int RESULT_BITS = 12;
    localparam int LEAD_ZEROS = 4;

    // ------------------------------------------------------------
    // falling edge counts within a frame
    // ------------------------------------------------------------
    localparam logic [4:0] TRACK_EDGE = 5'h0E;
    localparam logic [4:0] LAST_EDGE = 5'h10;
    localparam logic [4:0] PD_FIRST = 5'h04;
    localparam logic [4:0] PD_LIMIT = 5'h0B;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic {
        SACP_SELF = 1'b0,
        SACP_CLOCKED = 1'b1
    } sacp_mode_t;

    typedef enum logic [2:0] {
        SACP_M_IDLE = 3'b000,
        SACP_M_LEAD = 3'b001,
        SACP_M_HIGH = 3'b010,
        SACP_M_LOW = 3'b011,
        SACP_M_TAIL = 3'b100,
        SACP_M_QUIET = 3'b101
    } sacp_mst_t;

endpackage

/* File: rtl/sacp_if.sv */
`timescale 1ns/1ps
// chip_select_n doubles as convert_start_n in self-timed mode
interface sacp_if;
    logic chip_select_n;
    logic sclk;
    logic serial_out;
    logic serial_out_oe;

    modport device (
        input chip_select_n,
        input sclk,
        output serial_out,
        output serial_out_oe
    );

    modport master (
        output chip_select_n,
        output sclk,
        input serial_out,
        input serial_out_oe
    );
endinterface

/* File: rtl/sacp_edge_sync.sv */
`timescale 1ns/1ps
module sacp_edge_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // pin from another domain
    input wire logic i_pin,
    // synchronised level and edges, aligned
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic meta_r;
    logic sync_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
            o_level <= RST_VAL;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end else begin
            meta_r <= i_pin;
            sync_r <= meta_r;
            o_level <= sync_r;
            o_rise <= sync_r & ~o_level;
            o_fall <= ~sync_r & o_level;
        end
    end
endmodule

/* File: rtl/sacp_master.sv */
`timescale 1ns/1ps
module sacp_master #(
    parameter int HALF = sacp_pkg::SCLK_HALF,
    parameter int QUIET = sacp_pkg::QUIET_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // serial link
    sacp_if.master link,
    // user command
    input wire logic i_start,
    input wire logic i_cs_low,
    input wire logic [4:0] i_cycles,
    // user answer
    output logic o_busy,
    output logic o_done,
    output logic [sacp_pkg::WORD_BITS-1:0] o_data
);
    sacp_pkg::sacp_mst_t st_r;
    logic [7:0] div_r;
    logic [4:0] left_r;
    logic cs_r;
    logic sclk_r;
    logic [sacp_pkg::WORD_BITS-1:0] data_r;
    logic sd_lvl;

    // ------------------------------------------------------------
    // data line synchroniser
    // ------------------------------------------------------------
    sacp_edge_sync #(.RST_VAL(1'b0)) u_sd_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(link.serial_out),
        .o_level(sd_lvl),
        .o_rise(),
        .o_fall()
    );

    wire tick = (div_r == 8'h00);
    wire [7:0] half_ld = 8'(HALF - 1);
    wire [7:0] quiet_ld = 8'(QUIET - 1);

    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    // R08 sample on falls
    // R23 quiet after frame
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r <= sacp_pkg::SACP_M_IDLE;
            div_r <= 8'h00;
            left_r <= 5'h00;
            cs_r <= 1'b1;
            sclk_r <= 1'b0;
            data_r <= '0;
            o_data <= '0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            div_r <= tick ? 8'h00 : div_r - 8'h01;
            case (st_r)
                sacp_pkg::SACP_M_IDLE: begin
                    if (i_start) begin
                        cs_r <= ~i_cs_low;
                        left_r <= i_cycles;
                        div_r <= half_ld;
                        data_r <= '0;
                        st_r <= sacp_pkg::SACP_M_LEAD;
                    end
                end
                sacp_pkg::SACP_M_LEAD, sacp_pkg::SACP_M_LOW: begin
                    if (tick) begin
                        div_r <= half_ld;
                        if (left_r == 5'h00) begin
                            st_r <= sacp_pkg::SACP_M_TAIL;
                        end else begin
                            sclk_r <= 1'b1;
                            st_r <= sacp_pkg::SACP_M_HIGH;
                        end
                    end
                end
                sacp_pkg::SACP_M_HIGH: begin
                    if (tick) begin
                        div_r <= half_ld;
                        sclk_r <= 1'b0;
                        data_r <= {data_r[sacp_pkg::WORD_BITS-2:0], sd_lvl};
                        left_r <= left_r - 5'h01;
                        st_r <= sacp_pkg::SACP_M_LOW;
                    end
                end
                sacp_pkg::SACP_M_TAIL: begin
                    if (tick) begin
                        cs_r <= 1'b1;
                        div_r <= quiet_ld;
                        st_r <= sacp_pkg::SACP_M_QUIET;
                    end
                end
                sacp_pkg::SACP_M_QUIET: begin
                    if (tick) begin
                        o_data <= data_r;
                        o_done <= 1'b1;
                        st_r <= sacp_pkg::SACP_M_IDLE;
                    end
                end
                default: begin
                    st_r <= sacp_pkg::SACP_M_IDLE;
                end
            endcase
        end
    end

    // busy is a flop: high from the edge after start until done
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (st_r != sacp_pkg::SACP_M_IDLE) ? ~(st_r == sacp_pkg::SACP_M_QUIET & tick)
                : i_start;
        end
    end

    assign link.chip_select_n = cs_r;
    assign link.sclk = sclk_r;
endmodule

/* File: sim/sacp_link_assertions.sv */
`timescale 1ns/1ps
module sacp_link_assertions (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // link pins
    input wire logic chip_select_n,
    input wire logic sclk,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    // ------------------------------------------------------------
    // falling edges counted at the pin, ahead of the device sync
    // ------------------------------------------------------------
    logic sclk_r;
    logic cs_n_r;
    logic [4:0] fall_cnt_r;
    logic [4:0] fall_cnt_nxt;
    wire logic cs_fall = cs_n_r & ~chip_select_n;
    wire logic sclk_fall = sclk_r & ~sclk & ~chip_select_n;
    // no saturation here, so an extra edge shows up as 17
    assign fall_cnt_nxt = cs_fall ? 5'h00 : (sclk_fall ? fall_cnt_r + 5'h01 : fall_cnt_r);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            fall_cnt_r <= 5'h00;
        end else begin
            sclk_r <= sclk;
            cs_n_r <= chip_select_n;
            fall_cnt_r <= fall_cnt_nxt;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_first_zero_out: assert property (
        $rose(serial_out_oe) && !chip_select_n |-> !serial_out)
        else $error("first bit after select fall is not zero");
    chk_rise_releases_line: assert property (
        $rose(chip_select_n) |-> ##[1:6] !serial_out_oe)
        else $error("data line still driven after select rise");
    chk_release_at_last: assert property (
        sclk_fall && fall_cnt_r == 5'h0F |-> ##[3:6] !serial_out_oe)
        else $error("data line not released after last falling edge");
    chk_release_only_at_end: assert property (
        $fell(serial_out_oe) && !chip_select_n |-> fall_cnt_r == 5'h10)
        else $error("data line released early inside a frame");
    chk_lead_zeros_out: assert property (
        serial_out_oe && !chip_select_n && fall_cnt_r < 5'h03 |-> !serial_out)
        else $error("leading bit of the word is not zero");
    chk_bit_held_after: assert property (
        $fell(sclk) && !chip_select_n |=> $stable(serial_out)[*2])
        else $error("data bit changed right after a falling edge");
    chk_sclk_low_at_cs: assert property (
        $fell(chip_select_n) |-> !sclk)
        else $error("serial clock high at select fall");
    chk_edge_count_max: assert property (
        !chip_select_n |-> fall_cnt_r <= 5'h10)
        else $error("more than sixteen falling edges in a frame");
    chk_quiet_after_frame: assert property (
        $rose(chip_select_n) |-> chip_select_n[*8])
        else $error("select fell again before the quiet interval");
endmodule

/* File: sim/serial_adc_clocked_mode_power_ctrl_bench.sv */
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("mismatch at %0t got %h expected %h", $time, (got), (exp)); \
        end \
    end

module serial_adc_clocked_mode_power_ctrl_bench;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_start = 1'b0;
    logic i_cs_low = 1'b0;
    logic [4:0] i_cycles = 5'h00;
    logic [11:0] i_analog_input = 12'h000;
    logic m_busy;
    logic m_done;
    logic [15:0] m_data;
    logic d_hold;
    logic d_pd;
    logic d_mode;
    logic d_busy;
    logic d_ready;
    int err_count = 0;
    int comparisons = 0;
    logic [15:0] word;
    logic [15:0] mask;
    logic sclk_q;
    logic [4:0] fall_n;
    logic hold13;
    logic hold15;
    logic [4:0] cyc_tab [4] = '{5'h03, 5'h04, 5'h0A, 5'h0B};
    logic pd_tab [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [11:0] val_tab [2] = '{12'hFFF, 12'h801};

    always #12.5 i_clk = ~i_clk;

    sacp_if link();

    sacp_master sacp_master_i (.i_clk(i_clk), .i_rst(i_rst), .link(link), .i_start(i_start),
        .i_cs_low(i_cs_low), .i_cycles(i_cycles), .o_busy(m_busy), .o_done(m_done),
        .o_data(m_data));

    sacp_device sacp_device_i (.i_clk(i_clk), .i_rst(i_rst), .link(link),
        .i_analog_input(i_analog_input), .o_hold(d_hold), .o_analog_pd(d_pd),
        .o_clocked_mode(d_mode), .o_busy(d_busy), .o_result_ready(d_ready));

    sacp_link_assertions sacp_link_assertions_i (.i_clk(i_clk), .i_rst(i_rst),
        .chip_select_n(link.chip_select_n), .sclk(link.sclk), .serial_out(link.serial_out),
        .serial_out_oe(link.serial_out_oe));

    // hold seen late in the 14th and 16th bit slots of a frame
    always @(posedge i_clk) begin
        sclk_q <= link.sclk;
        if (link.chip_select_n) begin
            fall_n <= 5'h00;
        end else if (sclk_q && !link.sclk) begin
            fall_n <= fall_n + 5'h01;
        end
        if (fall_n == 5'h0D) begin
            hold13 <= d_hold;
        end
        if (fall_n == 5'h0F) begin
            hold15 <= d_hold;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic frame(input logic cs_low, input logic [4:0] cyc);
        int n;
        n = 0;
        @(posedge i_clk);
        i_start <= 1'b1;
        i_cs_low <= cs_low;
        i_cycles <= cyc;
        @(posedge i_clk);
        i_start <= 1'b0;
        while (m_done !== 1'b1 && n < 2000) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 2000) begin
            err_count++;
            end_sim();
        end else begin
            `CHK(m_busy, 1'b0);
        end
    endtask

    task automatic wait_ready(input int bound);
        int n;
        n = 0;
        while (d_ready !== 1'b1 && n < bound) begin
            @(posedge i_clk);
            n++;
        end
        if (d_ready !== 1'b1) begin
            err_count++;
            end_sim();
        end
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        `CHK(d_mode, 1'b0);
        `CHK(d_pd, 1'b0);
        $display("test reset done");

        // edgeless pulse starts a timed conversion, read with select high
        i_analog_input <= 12'h5A3;
        frame(1'b1, 5'h00);
        `CHK(d_busy, 1'b1);
        wait_ready(sacp_pkg::CONV_CYCLES);
        `CHK(d_ready, 1'b1);
        frame(1'b0, 5'h10);
        `CHK(m_data, {4'h0, 12'h5A3});
        `CHK(d_mode, 1'b0);
        `CHK(d_pd, 1'b0);
        $display("test self timed done");

        // edges during a running timed conversion force clocked mode
        frame(1'b1, 5'h00);
        frame(1'b1, 5'h02);
        `CHK(d_mode, 1'b1);
        `CHK(d_busy, 1'b0);
        repeat (150) @(posedge i_clk);
        `CHK(d_ready, 1'b0);
        `CHK(d_pd, 1'b0);
        $display("test mode switch done");

        for (int k = 0; k < 2; k++) begin
            i_analog_input <= val_tab[k];
            frame(1'b1, 5'h10);
            `CHK(m_data, {4'h0, val_tab[k]});
            `CHK(hold13, 1'b1);
            `CHK(hold15, 1'b0);
            `CHK(d_mode, 1'b1);
            `CHK(link.serial_out_oe, 1'b0);
        end
        $display("test clocked conversion done");

        // short frames: partial word, power-down window, wake attempts
        for (int k = 0; k < 4; k++) begin
            word = {4'h0, 12'h3C7 + 12'(k)};
            i_analog_input <= word[11:0];
            frame(1'b1, cyc_tab[k]);
            mask = (16'h0001 << cyc_tab[k]) - 16'h0001;
            `CHK(m_data & mask, word >> (5'h10 - cyc_tab[k]));
            `CHK(link.serial_out_oe, 1'b0);
            `CHK(d_pd, pd_tab[k]);
            `CHK(d_mode, 1'b1);
            if (pd_tab[k]) begin
                frame(1'b1, 5'h08);
                `CHK(d_pd, 1'b1);
                // full dummy, or eleven cycles once wake time has passed
                frame(1'b1, (k == 1) ? 5'h10 : 5'h0B);
                `CHK(d_pd, 1'b0);
            end
        end
        $display("test power down done");

        frame(1'b1, 5'h00);
        `CHK(d_mode, 1'b0);
        `CHK(d_pd, 1'b0);
        $display("test return to self timed done");
        end_sim();
    end
endmodule
